// *** design/dccm_top.sv ***
// DS-0 control code monitor, loop code generator and subrate formatter.
// Assumes office bytes and customer data arrive on aclk; AXI4-Lite slave.
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps

// Behaviour
// R1: All-zeros-data or idle pattern in bits 2-8 commands violation insertion.
// R2: All-zeros control pattern commands violation suppression.
// R3: Channel-unit loopback pattern inserts violation and raises its loopback request.
// R4: Channel loopback pattern raises channel request and suppresses violation.
// R5: Framing bit carries repeated 101100, one pattern bit per byte.
// R6: Subrate byte: six data, framing, control; 56 kb/s: seven data.
// R7: Each data byte followed by 19, 9 or 4 stuff bytes by rate.
// R8: Flywheel in channel-unit loopback sends loop code 0100001.
// R9: Option installed, not in loopback: send loop code 0101100.
// R10: Option absent, not in loopback: send loop code 010X011.
// R11: Loop codes for zero suppression, extension, not-ready and idle.
// R12: Marks alternate polarity; a violation repeats the last mark polarity.
module dccm_top
   import dccm_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Office DS-0 byte stream
   input wire logic [7:0] office_byte,
   input wire logic office_byte_valid,
   // Monitor commands
   output logic viol_insert_q,
   output logic viol_inhibit_q,
   output logic cu_loopback_req_q,
   output logic channel_loopback_req_q,
   // Customer data
   input wire logic [6:0] tx_data,
   input wire logic tx_ctrl,
   output logic tx_data_take_q,
   // Loop line
   output logic line_pos,
   output logic line_neg,
   // Interrupt
   output logic irq
);

   logic [7:0] ctrl_q;
   logic [3:0] int_stat_q;
   logic [3:0] int_mask_q;
   logic [6:0] last_code_q;
   dccm_fly_t fly_q;
   logic [2:0] fly_cnt_q;
   logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [8:0] sym_cnt_q;
   logic [2:0] bit_idx_q;
   logic [7:0] tx_shift_q;
   logic [4:0] stuff_q;
   logic [2:0] frame_idx_q;
   logic [6:0] data_hold_q;
   logic ctrl_hold_q;
   logic viol_slot_q;
   logic sym_en, byte_load, do_write, wr_ok;
   logic [6:0] pat;
   logic [3:0] events, w1c;
   dccm_rate_t rate;

   function automatic logic [4:0] stuff_count(input dccm_rate_t r);
      case (r)
         RATE_2K4: stuff_count = STUFF_2K4;
         RATE_4K8: stuff_count = STUFF_4K8;
         RATE_9K6: stuff_count = STUFF_9K6;
         default: stuff_count = STUFF_56K;
      endcase
   endfunction : stuff_count

   function automatic logic [6:0] loop_code(input dccm_sel_t s, input dccm_fly_t f,
                                            input logic opt);
      case (s)
         SEL_ZERO_SUPP: loop_code = CODE_ZERO_SUPP; // [R11]
         SEL_LOOP: loop_code = (f == FLY_CU_LOOP) ? CODE_CU_LOOP : // [R8]
                               opt ? CODE_OPT_LOOP : CODE_NOOPT_LOOP; // [R9] [R10]
         SEL_DME: loop_code = CODE_DME; // [R11]
         SEL_NR: loop_code = CODE_NR; // [R11]
         SEL_IDLE: loop_code = CODE_IDLE; // [R11]
         default: loop_code = CODE_IDLE;
      endcase
   endfunction : loop_code

   function automatic logic known_addr(input logic [7:0] a);
      known_addr = (a == REG_CTRL) || (a == REG_STATUS) ||
                   (a == REG_INT_STAT) || (a == REG_INT_MASK);
   endfunction : known_addr

   assign rate = dccm_rate_t'(ctrl_q[CTRL_RATE_LSB +: 2]);
   assign pat = office_byte[6:0];

   // AXI4-Lite slave
   assign awready = !aw_hold_q && !bvalid_q;
   assign wready = !w_hold_q && !bvalid_q;
   assign arready = !rvalid_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;
   assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
   assign wr_ok = do_write && known_addr({aw_addr_q[7:2], 2'b00});

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= known_addr({araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
         case ({araddr[7:2], 2'b00})
            REG_CTRL: rdata_q <= {24'h000000, ctrl_q};
            REG_STATUS: rdata_q <= {20'h00000, last_code_q, fly_q == FLY_CU_LOOP,
                                    channel_loopback_req_q, cu_loopback_req_q,
                                    viol_inhibit_q, viol_insert_q};
            REG_INT_STAT: rdata_q <= {28'h0000000, int_stat_q};
            REG_INT_MASK: rdata_q <= {28'h0000000, int_mask_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Control and mask registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RESET;
         int_mask_q <= INT_MASK_RESET;
      end else if (wr_ok && w_strb_q[0]) begin
         if ({aw_addr_q[7:2], 2'b00} == REG_CTRL) begin
            ctrl_q <= w_data_q[7:0];
         end
         if ({aw_addr_q[7:2], 2'b00} == REG_INT_MASK) begin
            int_mask_q <= w_data_q[3:0];
         end
      end
   end

   // Sticky interrupt status, set wins over clear
   assign w1c = (wr_ok && w_strb_q[0] && {aw_addr_q[7:2], 2'b00} == REG_INT_STAT) ?
                w_data_q[3:0] : 4'h0;
   assign events[INT_CU] = office_byte_valid && pat == PAT_CU_LOOP && !cu_loopback_req_q;
   assign events[INT_CHAN] = office_byte_valid && pat == PAT_CHAN_LOOP &&
                             !channel_loopback_req_q;
   assign events[INT_ZCTRL] = office_byte_valid && pat == PAT_ZERO_CTRL;
   assign events[INT_IDLE] = office_byte_valid && pat == PAT_IDLE;
   assign irq = |(int_stat_q & int_mask_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_stat_q <= 4'h0;
      end else begin
         int_stat_q <= (int_stat_q & ~w1c) | events;
      end
   end

   // Pattern monitor on each office byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         viol_insert_q <= 1'b0;
         viol_inhibit_q <= 1'b0;
         cu_loopback_req_q <= 1'b0;
         channel_loopback_req_q <= 1'b0;
         last_code_q <= 7'h00;
      end else if (office_byte_valid) begin
         last_code_q <= pat;
         viol_insert_q <= pat == PAT_ZERO_DATA || pat == PAT_IDLE || // [R1]
                          pat == PAT_CU_LOOP; // [R3]
         viol_inhibit_q <= pat == PAT_ZERO_CTRL || pat == PAT_CHAN_LOOP; // [R2] [R4]
         cu_loopback_req_q <= pat == PAT_CU_LOOP; // [R3]
         channel_loopback_req_q <= pat == PAT_CHAN_LOOP; // [R4]
      end
   end

   // Loopback flywheel: enter and leave after repeated agreement
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fly_q <= FLY_NORMAL;
         fly_cnt_q <= 3'h0;
      end else if (office_byte_valid) begin
         case (fly_q)
            FLY_NORMAL: begin
               if (pat != PAT_CU_LOOP) begin
                  fly_cnt_q <= 3'h0;
               end else if (fly_cnt_q + 3'h1 == FLY_COUNT) begin
                  fly_q <= FLY_CU_LOOP;
                  fly_cnt_q <= 3'h0;
               end else begin
                  fly_cnt_q <= fly_cnt_q + 3'h1;
               end
            end
            FLY_CU_LOOP: begin
               if (pat == PAT_CU_LOOP) begin
                  fly_cnt_q <= 3'h0;
               end else if (fly_cnt_q + 3'h1 == FLY_COUNT) begin
                  fly_q <= FLY_NORMAL;
                  fly_cnt_q <= 3'h0;
               end else begin
                  fly_cnt_q <= fly_cnt_q + 3'h1;
               end
            end
            default: begin
               fly_q <= FLY_NORMAL;
               fly_cnt_q <= 3'h0;
            end
         endcase
      end
   end

   // Line bit divider
   assign sym_en = sym_cnt_q == SYM_LAST;
   assign byte_load = sym_en && bit_idx_q == BIT_LAST;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sym_cnt_q <= 9'h000;
         bit_idx_q <= 3'h0;
      end else begin
         sym_cnt_q <= sym_en ? 9'h000 : sym_cnt_q + 9'h001;
         if (sym_en) begin
            bit_idx_q <= bit_idx_q + 3'h1;
         end
      end
   end

   // Byte formatter: data bytes, stuff repeats, framing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_shift_q <= 8'h00;
         stuff_q <= 5'h00;
         frame_idx_q <= 3'h0;
         data_hold_q <= 7'h00;
         ctrl_hold_q <= 1'b0;
         tx_data_take_q <= 1'b0;
         viol_slot_q <= 1'b0;
      end else begin
         tx_data_take_q <= 1'b0;
         if (byte_load) begin
            logic [6:0] d;
            logic c;
            logic f;
            d = (stuff_q == 5'h00) ? tx_data : data_hold_q;
            c = (stuff_q == 5'h00) ? tx_ctrl : ctrl_hold_q;
            f = FRAME_PATTERN[3'(FRAME_LAST - frame_idx_q)]; // [R5]
            if (stuff_q == 5'h00) begin
               data_hold_q <= tx_data;
               ctrl_hold_q <= tx_ctrl;
               tx_data_take_q <= 1'b1;
               stuff_q <= stuff_count(rate); // [R7]
            end else begin
               stuff_q <= stuff_q - 5'h01; // [R7]
            end
            frame_idx_q <= (frame_idx_q == FRAME_LAST) ? 3'h0 : frame_idx_q + 3'h1; // [R5]
            viol_slot_q <= viol_insert_q && !viol_inhibit_q;
            if (ctrl_q[CTRL_SEND_BIT]) begin
               tx_shift_q <= {1'b0, loop_code(dccm_sel_t'(ctrl_q[CTRL_SEL_LSB +: 3]), fly_q,
                                              ctrl_q[CTRL_OPT_BIT])};
            end else if (rate == RATE_56K) begin
               tx_shift_q <= {d, c}; // [R6]
            end else begin
               tx_shift_q <= {d[5:0], f, c}; // [R6]
            end
         end else if (sym_en) begin
            tx_shift_q <= {tx_shift_q[6:0], 1'b0};
         end
      end
   end

   dccm_bipolar_enc u_enc (
      .aclk(aclk),
      .aresetn(aresetn),
      .sym_en(sym_en),
      .sym_mark(ctrl_q[CTRL_EN_BIT] && tx_shift_q[7]),
      .sym_viol(ctrl_q[CTRL_EN_BIT] && viol_slot_q && bit_idx_q == BIT_LAST), // [R12]
      .line_pos_q(line_pos),
      .line_neg_q(line_neg)
   );

   // Checks
   logic [4:0] bytes_since_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || tx_data_take_q) begin
         bytes_since_q <= 5'h00;
      end else if (byte_load) begin
         bytes_since_q <= bytes_since_q + 5'h01;
      end
   end

   // Reference framing ring and rate of the last data byte
   logic [5:0] frame_ring_q;
   dccm_rate_t data_rate_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_ring_q <= FRAME_PATTERN;
         data_rate_q <= RATE_2K4;
      end else if (byte_load) begin
         frame_ring_q <= {frame_ring_q[4:0], frame_ring_q[5]};
         if (stuff_q == 5'h00) begin
            data_rate_q <= rate;
         end
      end
   end

   property p_zero_idle;
      @(posedge aclk) disable iff (!aresetn)
      office_byte_valid && (pat == PAT_ZERO_DATA || pat == PAT_IDLE)
         |=> viol_insert_q && !viol_inhibit_q;
   endproperty
   a_zero_idle: assert property (p_zero_idle) else $error("no insert for data/idle"); // [R1]

   property p_zero_ctrl;
      @(posedge aclk) disable iff (!aresetn)
      office_byte_valid && pat == PAT_ZERO_CTRL |=> viol_inhibit_q && !viol_insert_q;
   endproperty
   a_zero_ctrl: assert property (p_zero_ctrl) else $error("no inhibit for control"); // [R2]

   property p_cu_loop;
      @(posedge aclk) disable iff (!aresetn)
      office_byte_valid && pat == PAT_CU_LOOP |=> viol_insert_q && cu_loopback_req_q;
   endproperty
   a_cu_loop: assert property (p_cu_loop) else $error("unit loopback missed"); // [R3]

   property p_chan_loop;
      @(posedge aclk) disable iff (!aresetn)
      office_byte_valid && pat == PAT_CHAN_LOOP
         |=> channel_loopback_req_q && viol_inhibit_q && !viol_insert_q;
   endproperty
   a_chan_loop: assert property (p_chan_loop) else $error("channel loopback missed"); // [R4]

   property p_frame;
      @(posedge aclk) disable iff (!aresetn)
      byte_load && !ctrl_q[CTRL_SEND_BIT] && rate != RATE_56K
         |=> tx_shift_q[1] == $past(frame_ring_q[5]);
   endproperty
   a_frame: assert property (p_frame) else $error("framing bit wrong"); // [R5]

   property p_subrate_data;
      @(posedge aclk) disable iff (!aresetn)
      byte_load && stuff_q == 5'h00 && !ctrl_q[CTRL_SEND_BIT] && rate != RATE_56K
         |=> tx_shift_q[7:2] == $past(tx_data[5:0]) && tx_shift_q[0] == $past(tx_ctrl);
   endproperty
   a_subrate_data: assert property (p_subrate_data) else $error("subrate byte wrong"); // [R6]

   property p_stuff;
      @(posedge aclk) disable iff (!aresetn)
      byte_load && stuff_q == 5'h00 && bytes_since_q != 5'h00
         |-> bytes_since_q == stuff_count(data_rate_q);
   endproperty
   a_stuff: assert property (p_stuff) else $error("stuff count wrong"); // [R7]

   property p_code_cu;
      @(posedge aclk) disable iff (!aresetn)
      byte_load && ctrl_q[CTRL_SEND_BIT] && ctrl_q[CTRL_SEL_LSB +: 3] == SEL_LOOP &&
         fly_q == FLY_CU_LOOP |=> tx_shift_q[6:0] == CODE_CU_LOOP;
   endproperty
   a_code_cu: assert property (p_code_cu) else $error("unit loop code wrong"); // [R8]

   property p_code_opt;
      @(posedge aclk) disable iff (!aresetn)
      byte_load && ctrl_q[CTRL_SEND_BIT] && ctrl_q[CTRL_SEL_LSB +: 3] == SEL_LOOP &&
         fly_q == FLY_NORMAL |=> tx_shift_q[6:0] ==
         ($past(ctrl_q[CTRL_OPT_BIT]) ? CODE_OPT_LOOP : CODE_NOOPT_LOOP);
   endproperty
   a_code_opt: assert property (p_code_opt) else $error("option loop code wrong"); // [R9] [R10]

   property p_code_idle;
      @(posedge aclk) disable iff (!aresetn)
      byte_load && ctrl_q[CTRL_SEND_BIT] && ctrl_q[CTRL_SEL_LSB +: 3] == SEL_IDLE
         |=> tx_shift_q[6:0] == CODE_IDLE;
   endproperty
   a_code_idle: assert property (p_code_idle) else $error("idle code wrong"); // [R11]

   c_cu: cover property (@(posedge aclk) disable iff (!aresetn) fly_q == FLY_CU_LOOP);
   c_chan: cover property (@(posedge aclk) disable iff (!aresetn) channel_loopback_req_q);
   c_take: cover property (@(posedge aclk) disable iff (!aresetn) tx_data_take_q && irq);

endmodule : dccm_top

// *** design/dccm_pkg.sv ***
// Constants, field layout and types for the DS-0 control code monitor.
// Assumes a single 25 MHz clock and an AXI4-Lite register port.
package dccm_pkg;

   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int SYM_PERIOD_NS = 15625;
   localparam int SYM_CYCLES = SYM_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [8:0] SYM_LAST = 9'(SYM_CYCLES - 1);
   localparam logic [2:0] BIT_LAST = 3'h7;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_INT_STAT = 8'h08;
   localparam logic [7:0] REG_INT_MASK = 8'h0C;

   // Control register fields, control and mask reset values
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_RATE_LSB = 1;
   localparam int CTRL_OPT_BIT = 3;
   localparam int CTRL_SEND_BIT = 4;
   localparam int CTRL_SEL_LSB = 5;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [3:0] INT_MASK_RESET = 4'h0;

   // Interrupt status bits
   localparam int INT_CU = 0;
   localparam int INT_CHAN = 1;
   localparam int INT_ZCTRL = 2;
   localparam int INT_IDLE = 3;

   // Office-side patterns, bits 2 to 8
   localparam logic [6:0] PAT_ZERO_DATA = 7'h01;
   localparam logic [6:0] PAT_ZERO_CTRL = 7'h00;
   localparam logic [6:0] PAT_CU_LOOP = 7'h2A;
   localparam logic [6:0] PAT_CHAN_LOOP = 7'h28;
   localparam logic [6:0] PAT_IDLE = 7'h7E;

   // Local loop codes, bits 2 to 8
   localparam logic [6:0] CODE_ZERO_SUPP = 7'h00;
   localparam logic [6:0] CODE_CU_LOOP = 7'h21;
   localparam logic [6:0] CODE_OPT_LOOP = 7'h2C;
   localparam logic [6:0] CODE_NOOPT_LOOP = 7'h23;
   localparam logic [6:0] CODE_DME = 7'h6A;
   localparam logic [6:0] CODE_NR = 7'h7A;
   localparam logic [6:0] CODE_IDLE = 7'h7E;

   // Framing, rate matching and flywheel count
   localparam logic [5:0] FRAME_PATTERN = 6'h2C;
   localparam logic [2:0] FRAME_LAST = 3'h5;
   localparam logic [4:0] STUFF_2K4 = 5'h13;
   localparam logic [4:0] STUFF_4K8 = 5'h09;
   localparam logic [4:0] STUFF_9K6 = 5'h04;
   localparam logic [4:0] STUFF_56K = 5'h00;
   localparam logic [2:0] FLY_COUNT = 3'h4;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {RATE_2K4, RATE_4K8, RATE_9K6, RATE_56K} dccm_rate_t;
   typedef enum logic [2:0] {SEL_ZERO_SUPP, SEL_LOOP, SEL_DME, SEL_NR, SEL_IDLE} dccm_sel_t;
   typedef enum logic {FLY_NORMAL, FLY_CU_LOOP} dccm_fly_t;

endpackage : dccm_pkg

// *** design/dccm_bipolar_enc.sv ***
// Bipolar line encoder: one symbol per enable, with forced violations.
// Assumes sym_en pulses once per line bit from the parent's divider.
`timescale 1ns/100ps
module dccm_bipolar_enc
   import dccm_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Symbol in
   input wire logic sym_en,
   input wire logic sym_mark,
   input wire logic sym_viol,
   // Line out
   output logic line_pos_q,
   output logic line_neg_q
);

   logic last_pos_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_pos_q <= 1'b0;
         line_neg_q <= 1'b0;
         last_pos_q <= 1'b0;
      end else if (sym_en) begin
         if (sym_viol) begin
            // Same polarity as the last mark [R12]
            line_pos_q <= last_pos_q;
            line_neg_q <= !last_pos_q;
         end else if (sym_mark) begin
            // Alternate mark polarity [R12]
            line_pos_q <= !last_pos_q;
            line_neg_q <= last_pos_q;
            last_pos_q <= !last_pos_q;
         end else begin
            line_pos_q <= 1'b0;
            line_neg_q <= 1'b0;
         end
      end
   end

   property p_alt_mark;
      @(posedge aclk) disable iff (!aresetn)
      sym_en && sym_mark && !sym_viol |=> line_pos_q == !$past(last_pos_q) && line_neg_q != line_pos_q;
   endproperty
   a_alt_mark: assert property (p_alt_mark) else $error("mark did not alternate"); // [R12]

   property p_viol_same;
      @(posedge aclk) disable iff (!aresetn)
      sym_en && sym_viol |=> line_pos_q == $past(last_pos_q) && line_neg_q == !$past(last_pos_q);
   endproperty
   a_viol_same: assert property (p_viol_same) else $error("violation polarity wrong"); // [R12]

   c_viol: cover property (@(posedge aclk) disable iff (!aresetn) sym_en && sym_viol);

endmodule : dccm_bipolar_enc

// *** tb/dccm_line_partner.sv ***
// Loop-side partner: samples bipolar cells mid-way, rebuilds bytes.
// Assumes each byte starts on the line one bit after the customer take pulse.
`timescale 1ns/100ps
module dccm_line_partner
   import dccm_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Line and customer side
   input wire logic line_pos,
   input wire logic line_neg,
   input wire logic take,
   output logic [6:0] tx_data,
   output logic tx_ctrl,
   // Decoded bytes
   output logic [7:0] rx_byte,
   output logic rx_valid,
   output int viol_cnt
);
   logic [8:0] ph_q;
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   logic pol_q;
   logic mk;
   assign tx_data = 7'h55;
   assign tx_ctrl = 1'b1;
   assign mk = line_pos | line_neg;
   always_ff @(posedge aclk) begin
      rx_valid <= 1'b0;
      if (!aresetn) begin
         ph_q <= 9'h000;
         bit_q <= 3'h0;
         viol_cnt <= 0;
         pol_q <= 1'b0;
         sh_q <= 8'h00;
         rx_byte <= 8'h00;
      end else if (take) begin
         // Next sample is bit 8 of the byte still on the line
         ph_q <= 9'h000;
         bit_q <= 3'h7;
      end else begin
         ph_q <= (ph_q == SYM_LAST) ? 9'h000 : ph_q + 9'h001;
         if (ph_q == 9'h0C3) begin
            sh_q <= {sh_q[6:0], mk};
            bit_q <= bit_q + 3'h1;
            rx_valid <= (bit_q == BIT_LAST);
            rx_byte <= {sh_q[6:0], mk};
            // Same polarity as last mark counts as a violation
            if ((line_pos && pol_q) || (line_neg && !pol_q))
               viol_cnt <= viol_cnt + 1;
            if (mk)
               pol_q <= line_pos;
         end
      end
   end
endmodule : dccm_line_partner

// *** tb/dccm_top_tb.sv ***
// Bench: AXI4-Lite register tasks, office byte stimulus, line checks.
// Assumes the line partner model rebuilds bytes from the loop line.
`timescale 1ns/100ps
module dccm_top_tb
   import dccm_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [7:0] office_byte = 8'h00;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic office_byte_valid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic [31:0] rdata;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, vi, vn, cur, chr, take, lp, ln, irq, txc, rxv;
   logic [6:0] txd;
   logic [7:0] rxb;
   int vc, v0, c, i;
   int failures = 0;
   int num_checks = 0;
   logic [5:0] f;
   logic ok;
   logic [6:0] pat [5] = '{PAT_ZERO_DATA, PAT_ZERO_CTRL, PAT_CU_LOOP, PAT_CHAN_LOOP, PAT_IDLE};
   logic [3:0] ex [5] = '{4'h8, 4'h4, 4'hA, 4'h5, 4'h8};
   logic [7:0] cs [4] = '{8'h17, 8'h57, 8'h77, 8'h97};
   logic [6:0] cc [4] = '{CODE_ZERO_SUPP, CODE_DME, CODE_NR, CODE_IDLE};
   always #20 aclk = ~aclk;
   dccm_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .office_byte(office_byte), .office_byte_valid(office_byte_valid), .viol_insert_q(vi),
      .viol_inhibit_q(vn), .cu_loopback_req_q(cur), .channel_loopback_req_q(chr),
      .tx_data(txd), .tx_ctrl(txc), .tx_data_take_q(take), .line_pos(lp), .line_neg(ln),
      .irq(irq));
   dccm_line_partner peer (.aclk(aclk), .aresetn(aresetn), .line_pos(lp), .line_neg(ln),
      .take(take), .tx_data(txd), .tx_ctrl(txc), .rx_byte(rxb), .rx_valid(rxv),
      .viol_cnt(vc));
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tmo;
      failures++;
      $display("ERROR %0t: wait ran out", $time);
      test_done();
   endtask : tmo
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      if (n == 50)
         tmo();
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      if (n == 50)
         tmo();
      rready <= 1'b0;
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
   endtask : rd
   task automatic ob(input logic [6:0] p);
      @(posedge aclk);
      office_byte <= {1'b0, p};
      office_byte_valid <= 1'b1;
      @(posedge aclk);
      office_byte_valid <= 1'b0;
      @(posedge aclk);
   endtask : ob
   // Waits for a take pulse (r=0) or a rebuilt byte (r=1)
   task automatic wt(input logic r, output int n);
      for (n = 1; n < 70000 && (r ? rxv : take) !== 1'b1; n++)
         @(posedge aclk);
      if (n == 70000)
         tmo();
      @(posedge aclk);
   endtask : wt
   task automatic lc(input logic [7:0] ctl, input logic [6:0] code);
      wr(REG_CTRL, {24'h0, ctl}, RESP_OKAY);
      wt(1'b1, c);
      wt(1'b1, c);
      chk({24'h0, rxb}, {25'h0, code});
   endtask : lc
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(REG_CTRL, {24'h0, CTRL_RESET}, RESP_OKAY);
      rd(REG_INT_MASK, {28'h0, INT_MASK_RESET}, RESP_OKAY);
      rd(8'h10, 32'h0, RESP_SLVERR);
      wr(8'h10, 32'h1, RESP_SLVERR);
      wr(REG_INT_MASK, 32'h1, RESP_OKAY);
      for (i = 0; i < 5; i++) begin
         ob(pat[i]);
         chk({28'h0, vi, vn, cur, chr}, {28'h0, ex[i]});
      end
      chk({31'h0, irq}, 32'h1);
      rd(REG_INT_STAT, 32'hF, RESP_OKAY);
      rd(REG_STATUS, 32'hFC1, RESP_OKAY);
      wr(REG_INT_STAT, 32'h1, RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      $display("Register and monitor test done");
      ob(PAT_ZERO_CTRL);
      // Full rate set before the first byte load keeps the run short
      wr(REG_CTRL, 32'h7, RESP_OKAY);
      wt(1'b0, c);
      wt(1'b0, c);
      chk(c, 8 * SYM_CYCLES);
      wt(1'b1, c);
      chk({24'h0, rxb}, 32'hAB);
      v0 = vc;
      wt(1'b1, c);
      wt(1'b1, c);
      chk(vc, v0);
      ob(PAT_ZERO_DATA);
      v0 = vc;
      wt(1'b1, c);
      wt(1'b1, c);
      chk({31'h0, vc > v0}, 32'h1);
      $display("Line violation test done");
      wr(REG_CTRL, 32'h5, RESP_OKAY);
      wt(1'b0, c);
      wt(1'b0, c);
      chk(c, 5 * 8 * SYM_CYCLES);
      for (i = 0; i < 6; i++) begin
         wt(1'b1, c);
         f = {f[4:0], rxb[1]};
         chk({24'h0, rxb[7:2], rxb[0]}, 32'h2B);
      end
      ok = 1'b0;
      for (i = 0; i < 6; i++)
         ok |= (f == 6'({FRAME_PATTERN, FRAME_PATTERN} >> i));
      chk({31'h0, ok}, 32'h1);
      $display("Subrate test done");
      for (i = 0; i < 4; i++)
         ob(PAT_CU_LOOP);
      rd(REG_STATUS, 32'h555, RESP_OKAY);
      lc(8'h37, CODE_CU_LOOP);
      for (i = 0; i < 4; i++)
         ob(PAT_ZERO_CTRL);
      lc(8'h3F, CODE_OPT_LOOP);
      lc(8'h37, CODE_NOOPT_LOOP);
      for (i = 0; i < 4; i++)
         lc(cs[i], cc[i]);
      $display("Loop code test done");
      test_done();
   end
endmodule : dccm_top_tb
